// *** pkg/lcdc_map.svh ***
// offsets, field positions, reset values and timing counts of the lcd control
// assumes a 32-bit axi4-lite slave with one register per aligned word
`ifndef LCDC_MAP_SVH
`define LCDC_MAP_SVH

// register indices as printed; byte address is four times the index
`define LCDC_IDX_PIN_CONFIG  8'hc0
`define LCDC_IDX_CONTROL     8'hc1
`define LCDC_IDX_CONTROL_TWO 8'hc2
`define LCDC_ADDR_W          12

// lcd_control fields
`define LCDC_CTL_POWER   6
`define LCDC_CTL_ACT     5
`define LCDC_CTL_SHOW    4
`define LCDC_CTL_RESET   8'h80
`define LCDC_CTL_WMASK   8'h7f

// lcd_control_two fields
`define LCDC_CT2_WAVE    7
`define LCDC_CT2_RESET   8'h60
`define LCDC_CT2_WMASK   8'h9f

// lcd_pin_config fields
`define LCDC_PIN_RESET   8'h00

// axi responses
`define LCDC_RESP_OKAY   2'b00
`define LCDC_RESP_SLVERR 2'b10

// index of the last charge pulse slot; eight slots per duty period
`define LCDC_CHARGE_SLOTS 3'h7

`endif

// *** pkg/lcdc_pkg.sv ***
// types shared by the lcd control block
// assumes lcdc_map.svh supplies the numbers
package lcdc_pkg;
    // duty of the frame, from the two duty select bits
    typedef enum logic [1:0] {
        LCDC_DUTY_STATIC,
        LCDC_DUTY_HALF,
        LCDC_DUTY_THIRD,
        LCDC_DUTY_QUARTER
    } lcdc_duty_type;

    // bus write channel progress
    typedef enum logic [1:0] {
        LCDC_WR_IDLE,
        LCDC_WR_RESP
    } lcdc_wr_type;
endpackage : lcdc_pkg

// *** pkg/lcdc_tick_if.sv ***
// carries the frame tick and run state from clock divider to frame timing
// assumes both ends run on the same aclk
`timescale 1ns/1ps
interface lcdc_tick_if;
    logic run;
    logic tick;
    modport source (output run, output tick);
    modport sink   (input  run, input  tick);
endinterface : lcdc_tick_if

// *** src/lcdc_clock_div.sv ***
// operating clock enable for the frame logic
// assumes subclock arrives as an asynchronous level from a pin
`timescale 1ns/1ps
`include "lcdc_map.svh"
module lcdc_clock_div
    import lcdc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       subclock,
    input  wire logic       active,
    input  wire logic [3:0] clock_select,
    lcdc_tick_if.source     tick_port
);
    logic [2:0] sub_sync_q;
    logic [7:0] sys_cnt_q;
    logic [1:0] sub_cnt_q;
    logic       sub_edge;
    logic       tick_d;

    // two flops, then a third for the edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_sync_q <= 3'h0;
        end else begin
            sub_sync_q <= {sub_sync_q[1:0], subclock};
        end
    end
    assign sub_edge = sub_sync_q[1] & ~sub_sync_q[2];

    // counters idle while halted [RULE_07]
    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            sys_cnt_q <= 8'h00;
            sub_cnt_q <= 2'h0;
        end else begin
            sys_cnt_q <= sys_cnt_q + 8'h01;
            if (sub_edge) begin
                sub_cnt_q <= sub_cnt_q + 2'h1;
            end
        end
    end

    // subclock /1 /2 /4 or system clock /2 .. /256 [RULE_04]
    always_comb begin
        tick_d = 1'b0;
        if (!clock_select[3]) begin
            case (clock_select[1:0])
                2'h0:    tick_d = sub_edge;
                2'h1:    tick_d = sub_edge & sub_cnt_q[0];
                default: tick_d = sub_edge & (&sub_cnt_q);
            endcase
        end else begin
            // divisor 2^(n+1): all low n+1 count bits set
            tick_d = &(sys_cnt_q | ~((8'h02 << clock_select[2:0]) - 8'h01));
        end
    end

    assign tick_port.run  = active;
    assign tick_port.tick = tick_d & active; // [RULE_02]
endmodule : lcdc_clock_div

// *** src/lcdc_frame_timing.sv ***
// frame timing: common phase, memory fetch and charge pulse
// assumes a one-cycle tick from lcdc_clock_div
`timescale 1ns/1ps
`include "lcdc_map.svh"
module lcdc_frame_timing
    import lcdc_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    lcdc_tick_if.sink          tick_port,
    input  wire lcdc_duty_type duty,
    input  wire logic [2:0]    charge_duty,
    output logic [1:0]         common_index,
    output logic               frame_start,
    output logic               fetch_strobe,
    output logic               charge_pulse
);
    logic [1:0] phase_q;
    logic [2:0] slot_q;
    logic [1:0] last_phase;

    // last common index for each duty [RULE_06]
    always_comb begin
        case (duty)
            LCDC_DUTY_STATIC: last_phase = 2'h0;
            LCDC_DUTY_HALF:   last_phase = 2'h1;
            LCDC_DUTY_THIRD:  last_phase = 2'h2;
            default:          last_phase = 2'h3;
        endcase
    end

    // common and slot counters, held at zero while halted [RULE_07]
    always_ff @(posedge aclk) begin
        if (!aresetn || !tick_port.run) begin
            phase_q <= 2'h0;
            slot_q  <= 3'h0;
        end else if (tick_port.tick) begin
            slot_q <= slot_q + 3'h1;
            if (slot_q == `LCDC_CHARGE_SLOTS) begin
                phase_q <= (phase_q >= last_phase) ? 2'h0
                                                   : phase_q + 2'h1;
            end
        end
    end

    // outputs registered; fetch only when running [RULE_07]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            common_index <= 2'h0;
            frame_start  <= 1'b0;
            fetch_strobe <= 1'b0;
            charge_pulse <= 1'b0;
        end else begin
            common_index <= phase_q;
            fetch_strobe <= tick_port.tick && slot_q == 3'h0;
            frame_start  <= tick_port.tick && slot_q == 3'h0
                            && phase_q == 2'h0;
            // 000 full, 111 none, else n eighths [RULE_05]
            if (!tick_port.run || charge_duty == 3'h7) begin
                charge_pulse <= 1'b0;
            end else if (charge_duty == 3'h0) begin
                charge_pulse <= 1'b1;
            end else begin
                charge_pulse <= slot_q < charge_duty;
            end
        end
    end
endmodule : lcdc_frame_timing

// *** src/lcdc_control.sv ***
// lcd controller control registers with an axi4-lite slave
// assumes one aclk; subclock is an asynchronous pin level
// How it works
// RULE_01: power bit set turns the lcd drive supply on; resets cleared.
// RULE_02: activate bit cleared halts the controller; set lets it run.
// RULE_03: show bit set displays memory; cleared gives a blank display. Code also blanks while the activate bit is cleared.
// RULE_04: clock field picks subclock /1,/2,/4 or system clock /2../256.
// RULE_05: charge duty code 000 full, 001-110 n eighths, 111 zero.
// RULE_06: frame timing follows static, half, third or quarter duty.
// RULE_07: while halted, counters idle and no memory fetch happens.
`timescale 1ns/1ps
`include "lcdc_map.svh"
module lcdc_control
    import lcdc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        subclock,
    output logic             drive_power_on,
    output logic             display_memory_show,
    output logic             waveform_type_select,
    output logic [1:0]       common_index,
    output logic             frame_start,
    output logic             fetch_strobe,
    output logic             charge_pulse
);
    // ******************************************************************
    // registers and address decode
    // ******************************************************************
    logic [7:0]  pin_config_q;
    logic [7:0]  control_q;
    logic [7:0]  control_two_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [11:0] awaddr_q;
    logic [7:0]  wdata_q;
    logic        wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        do_write;

    lcdc_tick_if tick_bus ();

    // maps a byte address to a known register; aligned words only
    function automatic logic addr_hit(input logic [11:0] addr);
        addr_hit = addr[1:0] == 2'h0 &&
                   (addr[9:2] == `LCDC_IDX_PIN_CONFIG ||
                    addr[9:2] == `LCDC_IDX_CONTROL ||
                    addr[9:2] == `LCDC_IDX_CONTROL_TWO) &&
                   addr[11:10] == 2'h0;
    endfunction : addr_hit

    // ******************************************************************
    // write channel
    // ******************************************************************
    // address and data accepted in either order, held until both arrive
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 8'h00;
            wstrb_q   <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata[7:0];
                wstrb_q  <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `LCDC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_hit(awaddr_q) ? `LCDC_RESP_OKAY
                                           : `LCDC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // register store; fixed bits keep their reset level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_config_q  <= `LCDC_PIN_RESET;
            control_q     <= `LCDC_CTL_RESET;   // [RULE_01] [RULE_02]
            control_two_q <= `LCDC_CT2_RESET;
        end else if (do_write && wstrb_q && awaddr_q[11:10] == 2'h0) begin
            case (awaddr_q[9:2])
                `LCDC_IDX_PIN_CONFIG: pin_config_q <= wdata_q;
                `LCDC_IDX_CONTROL:
                    control_q <= (wdata_q & `LCDC_CTL_WMASK)
                               | (`LCDC_CTL_RESET & ~`LCDC_CTL_WMASK);
                `LCDC_IDX_CONTROL_TWO:
                    control_two_q <= (wdata_q & `LCDC_CT2_WMASK)
                                   | (`LCDC_CT2_RESET & ~`LCDC_CT2_WMASK);
                default: ;
            endcase
        end
    end

    // ******************************************************************
    // read channel
    // ******************************************************************
    // one read at a time; answer one cycle after the address is taken
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `LCDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= addr_hit(s_axi_araddr) ? `LCDC_RESP_OKAY
                                               : `LCDC_RESP_SLVERR;
            case (s_axi_araddr[9:2])
                `LCDC_IDX_PIN_CONFIG:  rdata_q <= {24'h0, pin_config_q};
                `LCDC_IDX_CONTROL:     rdata_q <= {24'h0, control_q};
                `LCDC_IDX_CONTROL_TWO: rdata_q <= {24'h0, control_two_q};
                default:               rdata_q <= 32'h0000_0000;
            endcase
            if (!addr_hit(s_axi_araddr)) begin
                rdata_q <= 32'h0000_0000;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ******************************************************************
    // controller steering
    // ******************************************************************
    // supply follows its bit directly so software can settle it first
    assign drive_power_on = control_q[`LCDC_CTL_POWER]; // [RULE_01]

    // blanking is forced while halted too, so the glass never sees stale
    // memory contents after a restart
    assign display_memory_show = control_q[`LCDC_CTL_SHOW] // [RULE_03]
                               & control_q[`LCDC_CTL_ACT];
    assign waveform_type_select = control_two_q[`LCDC_CT2_WAVE];

    lcdc_clock_div u_clock_div (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .subclock     (subclock),
        .active       (control_q[`LCDC_CTL_ACT]),   // [RULE_02]
        .clock_select (control_q[3:0]),             // [RULE_04]
        .tick_port    (tick_bus.source)
    );

    lcdc_frame_timing u_frame_timing (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .tick_port    (tick_bus.sink),
        .duty         (lcdc_duty_type'(pin_config_q[7:6])), // [RULE_06]
        .charge_duty  (control_two_q[2:0]),                 // [RULE_05]
        .common_index (common_index),
        .frame_start  (frame_start),
        .fetch_strobe (fetch_strobe),                       // [RULE_07]
        .charge_pulse (charge_pulse)
    );
endmodule : lcdc_control

// *** test/lcdc_control_checker.sv ***
// concurrent checks on the ports of lcdc_control
// assumes write address and data are offered together by the master
`timescale 1ns/1ps
module lcdc_control_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        drive_power_on,
    input wire logic        display_memory_show,
    input wire logic        frame_start,
    input wire logic        fetch_strobe,
    input wire logic        charge_pulse
);
    // ****************************************
    // shadow of power, activate and show bits
    // ****************************************
    logic [2:0] shadow_q;
    logic       wr_hs;
    assign wr_hs = s_axi_awvalid && s_axi_awready
                   && s_axi_wvalid && s_axi_wready;
    // the design may land a write a cycle late, hence the settle counts
    always_ff @(posedge aclk) begin
        if (!aresetn)
            shadow_q <= 3'h0;
        else if (wr_hs && s_axi_awaddr == 12'h304 && s_axi_wstrb[0])
            shadow_q <= s_axi_wdata[6:4];
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_power_level: assert property ($stable(shadow_q[2]) [*4]
        |-> drive_power_on == shadow_q[2]) else $error("power level wrong");
    chk_halt_no_fetch: assert property ((!shadow_q[1]) [*5]
        |-> !fetch_strobe && !frame_start) else $error("fetch while halted");
    chk_show_blank: assert property ((shadow_q[1:0] != 2'h3) [*5]
        |-> !display_memory_show) else $error("display not blanked");
    chk_show_memory: assert property ((shadow_q[1:0] == 2'h3) [*5]
        |-> display_memory_show) else $error("display memory hidden");
    chk_write_answer: assert property (wr_hs |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready
        && !(s_axi_araddr inside {12'h300, 12'h304, 12'h308})
        |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    chk_busy_refuse: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    chk_fetch_pulse: assert property (fetch_strobe |=> !fetch_strobe)
        else $error("fetch strobe too long");
    cov_fetch: cover property (fetch_strobe);
    cov_show: cover property ($rose(display_memory_show));
    cov_charge: cover property ($rose(charge_pulse));
    cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : lcdc_control_checker

bind lcdc_control lcdc_control_checker i_lcdc_control_checker (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .drive_power_on, .display_memory_show, .frame_start, .fetch_strobe,
    .charge_pulse);

// *** test/lcdc_panel_model.sv ***
// passive lcd glass: counts memory fetches and highest common phase
// assumes the glass only loads the drivers and never answers back
`timescale 1ns/1ps
module lcdc_panel_model (
    input wire logic       aclk,
    input wire logic       clear,
    input wire logic       fetch_strobe,
    input wire logic [1:0] common_index,
    output int             fetches,
    output logic [1:0]     max_com
);
    // glass has no handshake, so the bench reads these tallies
    always @(posedge aclk) begin
        if (clear) begin
            fetches <= 0;
            max_com <= 2'h0;
        end else begin
            if (fetch_strobe)
                fetches <= fetches + 1;
            if (common_index > max_com)
                max_com <= common_index;
        end
    end
endmodule : lcdc_panel_model

// *** test/tb.sv ***
// self-checking bench for lcdc_control with a passive panel model
// assumes a 10 mhz aclk and a subclock of 32 aclk cycles
`timescale 1ns/1ps
module tb;
    import lcdc_pkg::*;
    localparam logic [11:0] A_PIN = 12'h300;
    localparam logic [11:0] A_CTL = 12'h304;
    localparam logic [11:0] A_CT2 = 12'h308;
    logic        aclk, aresetn, clear, s_axi_awvalid, s_axi_wvalid;
    logic        subclock = 1'b0;
    logic        s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        drive_power_on, display_memory_show, waveform_type_select;
    logic        frame_start, fetch_strobe, charge_pulse;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, common_index, max_com;
    logic [4:0]  sub_cnt = 5'h0;
    int          fetches, num_errors, n_compared;

    lcdc_control i_lcdc_control (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .subclock,
        .drive_power_on, .display_memory_show, .waveform_type_select,
        .common_index, .frame_start, .fetch_strobe, .charge_pulse);
    lcdc_panel_model i_lcdc_panel_model (.aclk, .clear, .fetch_strobe,
        .common_index, .fetches, .max_com);

    // ****************************************
    // clock, subclock and shared tasks
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // subclock made from aclk so its edges never race the sampling edge
    always @(posedge aclk) begin
        sub_cnt <= sub_cnt + 5'h1;
        subclock <= sub_cnt[4];
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask : check
    task automatic test_done;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
        check(32'(n < 200), 32'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
        check(32'(n < 200), 32'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // third gap is clean; the first starts mid phase
    task automatic fetch_gap(output int g);
        for (int k = 0; k < 3; k++) begin
            g = 0;
            do begin
                @(posedge aclk);
                g++;
            end while (!fetch_strobe && g < 9000);
        end
    endtask : fetch_gap

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rd(A_PIN, d, r);
        check(d, 32'h0);
        rd(A_CTL, d, r);
        check(d, 32'h80);
        rd(A_CT2, d, r);
        check(d, 32'h60);
        wr(A_CT2, 8'h80, r);
        rd(A_CT2, d, r);
        check(d, 32'he0);
        check(32'(waveform_type_select), 32'h1);
        wr(A_CTL, 8'h7f, r);
        check(32'(r), 32'h0);
        rd(A_CTL, d, r);
        check(d, 32'hff);
        rd(12'h30c, d, r);
        check(d, 32'h0);
        check(32'(r), 32'h2);
        wr(12'h30c, 8'h00, r);
        check(32'(r), 32'h2);
        rd(12'h305, d, r);
        check(32'(r), 32'h2);
    endtask : t_regs
    task automatic t_show;
        logic [7:0] v [4] = '{8'h70, 8'h50, 8'h20, 8'h40};
        logic [1:0] r;
        for (int k = 0; k < 4; k++) begin
            wr(A_CTL, v[k], r);
            repeat (5) @(posedge aclk);
            check(32'(display_memory_show), 32'(k == 0));
            check(32'(drive_power_on), 32'(v[k][6]));
        end
    endtask : t_show
    task automatic t_clock;
        logic [3:0] c [12] = '{0, 1, 2, 3, 8, 9, 10, 11, 12, 13, 14, 15};
        logic [1:0] r;
        int         g;
        for (int k = 0; k < 12; k++) begin
            wr(A_CTL, {4'h2, c[k]}, r);
            fetch_gap(g);
            check(g, c[k][3] ? 8 << (c[k][2:0] + 1)
                  : 256 << (c[k][1] ? 2 : c[k][0]));
        end
    endtask : t_clock
    task automatic t_duty_halt;
        logic [1:0] r;
        int         g;
        for (int d = 0; d < 4; d++) begin
            wr(A_PIN, 8'(d << 6), r);
            wr(A_CTL, 8'h68, r);
            clear <= 1'b1;
            @(posedge aclk);
            clear <= 1'b0;
            repeat (400) @(posedge aclk);
            check(32'(max_com), d);
            check(32'(fetches >= 12), 32'h1);
            // a frame opens on the first common with a fetch
            g = 0;
            do begin
                @(posedge aclk);
                g++;
            end while (!frame_start && g < 200);
            check(32'(frame_start & fetch_strobe), 32'h1);
            check(32'(common_index), 32'h0);
        end
        wr(A_CTL, 8'h48, r);
        clear <= 1'b1;
        repeat (3) @(posedge aclk);
        clear <= 1'b0;
        repeat (600) @(posedge aclk);
        check(fetches, 0);
    endtask : t_duty_halt
    task automatic t_charge;
        logic [1:0] r;
        int         cnt, e;
        wr(A_CTL, 8'h68, r);
        for (int c = 0; c < 8; c++) begin
            wr(A_CT2, 8'(c), r);
            repeat (32) @(posedge aclk);
            cnt = 0;
            repeat (1024) begin
                @(posedge aclk);
                cnt += charge_pulse;
            end
            e = c == 0 ? 1024 : c == 7 ? 0 : c * 128;
            check(32'(cnt + 32 >= e && cnt <= e + 32), 32'h1);
        end
    endtask : t_charge

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, clear} = 3'h0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h1;
        num_errors = 0;
        n_compared = 0;
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_show();
        t_clock();
        t_duty_halt();
        t_charge();
        test_done();
    end
    // whole run is near 30000 cycles, so this only trips on a hang
    initial begin
        repeat (95000) @(posedge aclk);
        num_errors++;
        test_done();
    end
endmodule : tb
